/* File: fmss_compare.sv */
`timescale 1ns/1ps
// running compare of read data against a reference byte stream
module fmss_compare #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// control
	input wire logic clear,
	input wire logic byte_en,
	// data
	input wire logic [W-1:0] rd_byte,
	input wire logic [W-1:0] ref_byte,
	// result
	output logic eq,
	output logic low
);
	typedef struct packed {
		logic eq;
		logic low;
		logic decided;
	} fmss_cmp_t;

	fmss_cmp_t st_reg, st_next;

	// first differing byte decides the order, like a string compare
	always_comb begin
		st_next = st_reg;
		if (clear) begin
			st_next.eq = 1'b1;
			st_next.low = 1'b0;
			st_next.decided = 1'b0;
		end else if (byte_en && !st_reg.decided && rd_byte != ref_byte) begin
			st_next.eq = 1'b0; // R13
			st_next.low = rd_byte < ref_byte; // R14
			st_next.decided = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '{eq: 1'b1, low: 1'b0, decided: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign eq = st_reg.eq;
	assign low = st_reg.low;

	// a first mismatch on an enabled byte drops equality
	cmp_mismatch_a: assert property (@(posedge clk) disable iff (!reset_n) // R13
		!clear && byte_en && !st_reg.decided && rd_byte != ref_byte
		|=> !eq && (low == $past(rd_byte < ref_byte)))
		else $error("compare result not taken from first mismatch");
endmodule : fmss_compare

/* File: fmss_mcu_model.sv */
`timescale 1ns/1ps
// microcontroller side of the register port
module fmss_mcu_model (
	// clock
	input wire logic clk,
	// register port
	output logic [7:0] mcu_addr,
	output logic [7:0] mcu_wdata,
	output logic mcu_wr,
	output logic mcu_rd,
	input wire logic [7:0] mcu_rdata
);
	// idle bus at time zero
	initial begin
		mcu_addr = 8'h00;
		mcu_wdata = 8'h00;
		mcu_wr = 1'h0;
		mcu_rd = 1'h0;
	end
	// gap idles first; the bus is inverted after the strobe so that
	// a stale byte can never pass for a live one
	task automatic xfer(input bit rd, input logic [7:0] a, d,
		input int gap, output logic [7:0] q);
		repeat (gap) @(negedge clk);
		@(negedge clk);
		mcu_addr = a;
		mcu_wdata = d;
		mcu_rd = rd;
		mcu_wr = !rd;
		@(negedge clk);
		q = mcu_rdata;
		mcu_rd = 1'h0;
		mcu_wr = 1'h0;
		mcu_addr = ~a;
		mcu_wdata = ~d;
	endtask : xfer
endmodule : fmss_mcu_model

/* File: fmss_pkg.sv */
package fmss_pkg;
	// register offsets on the local microcontroller port
	localparam logic [7:0] MODE_OFS = 8'h77;
	localparam logic [7:0] NADDR_OFS = 8'h78;
	localparam logic [7:0] STAT_OFS = 8'h79;
	// host register file windows, eight bytes each
	localparam logic [7:0] WIN_LO = 8'h40;
	localparam logic [7:0] WIN_HI = 8'h60;
	localparam logic [7:0] WIN_MASK = 8'hF8;
	// mode register fields
	localparam int M_HSR = 0;
	localparam int M_HACC = 1;
	localparam int M_HSEL = 2;
	localparam int M_INTEN = 3;
	localparam int M_PUDIS = 4;
	localparam int M_PIDX = 5;
	localparam int M_SOE = 6;
	localparam int M_HARD = 7;
	// control and count field bits of the current sequencer word
	localparam int C_XFER = 0;
	localparam int C_CMPEN = 1;
	localparam int C_GPIO = 2;
	localparam int CNT_MARK = 7;
	// reset values and address width
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [4:0] BRANCH_RST = 5'h00;
	localparam int ADDR_W = 5;
endpackage : fmss_pkg

/* File: fmss_regs.sv */
// Summary of operation
// R01: host status read sets flag; read clears
// R02: access disabled: neither host window decoded
// R03: decode select picks 40H or 60H window
// R04: enable bit gates whole local interrupt
// R05: pull-up disable makes interrupt open drain
// R06: programmed index bit acts as index
// R07: output enable drives control bit 2 out
// R08: sector bit picks hard or soft mode
// R09: hardware reset clears mode register
// R10: next-address read returns five-bit address
// R11: write at same offset loads branch address
// R12: branch address cleared by both resets
// R13: compare-equal over enabled bytes, valid in ECC
// R14: compare-low under same conditions
// R15: ECC error when syndrome non-zero at end
// R16: correctable flag valid after shift falls
// R17: stopped flag; halt drops read/write gates
// R18: branch active set on branch, read clears
// R19: transfer status mirrors control bit 0
// R20: mark flag set, cleared at ECC or stop
// R21: soft or hard reset stops formatter
// R22: single-byte accesses; clear on completed read
`timescale 1ns/1ps
module fmss_regs (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// microcontroller register port
	input wire logic [7:0] mcu_addr,
	input wire logic [7:0] mcu_wdata,
	input wire logic mcu_wr,
	input wire logic mcu_rd,
	output logic [7:0] mcu_rdata,
	// host window decode
	output logic host_file_hit,
	output logic ext_space_hit,
	// formatter control
	input wire logic soft_reset,
	input wire logic ecc_shift_ctrl,
	output logic fmt_hold,
	// sequencer word and state
	input wire logic [4:0] next_addr,
	input wire logic [7:0] ctrl_field,
	input wire logic [7:0] count_field,
	input wire logic branch_met,
	input wire logic seq_halted,
	input wire logic in_ecc_field,
	input wire logic op_start,
	output logic [4:0] branch_addr,
	// compare datapath
	input wire logic cmp_byte,
	input wire logic [7:0] read_byte,
	input wire logic [7:0] buf_byte,
	input wire logic [7:0] control_store_byte,
	input wire logic search_op,
	// error correction
	input wire logic ecc_last_bit,
	input wire logic syndrome_nz,
	input wire logic corr_found,
	input wire logic ecc_bytes_done,
	// host side event
	input wire logic host_status_read,
	// local interrupt pin
	input wire logic int_src,
	output logic int_o,
	output logic int_oe_n,
	output logic int_pullup_en,
	// general input/output pin
	output logic gpio_o,
	output logic gpio_oe_n,
	// index, sector and mark
	input wire logic index_in,
	input wire logic mark_or_sector_pin,
	output logic index_active,
	output logic hard_sector,
	output logic sector_edge,
	output logic mark_detect,
	// disk gates
	input wire logic read_gate_req,
	input wire logic write_gate_req,
	output logic read_gate,
	output logic write_gate
);
	typedef struct packed {
		logic [7:0] mode;
		logic [4:0] branch;
		logic ecc_err;
		logic corr;
		logic shift_prev;
		logic branch_act;
		logic mark_act;
		logic pin_prev;
		logic [7:0] rdata;
		logic host_hit;
		logic ext_hit;
		logic int_oe_n;
		logic pullup_en;
		logic gpio_o;
		logic gpio_oe_n;
		logic index_act;
		logic sector_edge;
		logic mark_det;
		logic rg;
		logic wg;
		logic hold;
	} fmss_state_t;

	fmss_state_t st_reg, st_next;
	logic cmp_eq, cmp_low;
	logic stopped;
	logic mode_hsr_q;
	logic [7:0] status;

	// address falls inside an eight-byte window
	function automatic logic fmss_in_win(input logic [7:0] a,
		input logic [7:0] base);
		fmss_in_win = (a & fmss_pkg::WIN_MASK) == base;
	endfunction : fmss_in_win

	// reference byte chosen by the search operation setting
	fmss_compare #(
		.W(8)
	) u_cmp (
		.clk(clk),
		.reset_n(reset_n),
		.clear(op_start | soft_reset),
		.byte_en(cmp_byte & ctrl_field[fmss_pkg::C_CMPEN]), // R13
		.rd_byte(read_byte),
		.ref_byte(search_op ? buf_byte : control_store_byte), // R13
		.eq(cmp_eq),
		.low(cmp_low)
	);

	// halt or soft reset means the sequencer stands still
	assign stopped = seq_halted | soft_reset; // R17 R21

	// status image; compare result is hidden until the ECC field
	always_comb begin
		status = 8'h00;
		status[0] = cmp_eq & in_ecc_field; // R13
		status[1] = cmp_low & in_ecc_field; // R14
		status[2] = st_reg.ecc_err; // R15
		status[3] = st_reg.corr; // R16
		status[4] = stopped; // R17
		status[5] = st_reg.branch_act; // R18
		status[6] = ctrl_field[fmss_pkg::C_XFER]; // R19
		status[7] = st_reg.mark_act; // R20
	end

	// next state of every register and registered output
	always_comb begin
		logic rd_mode;
		logic rd_stat;
		logic wr_mode;
		logic wr_br;
		logic in40;
		logic in60;
		rd_mode = mcu_rd && mcu_addr == fmss_pkg::MODE_OFS; // R22
		rd_stat = mcu_rd && mcu_addr == fmss_pkg::STAT_OFS; // R22
		wr_mode = mcu_wr && mcu_addr == fmss_pkg::MODE_OFS;
		wr_br = mcu_wr && mcu_addr == fmss_pkg::NADDR_OFS;
		in40 = fmss_in_win(mcu_addr, fmss_pkg::WIN_LO);
		in60 = fmss_in_win(mcu_addr, fmss_pkg::WIN_HI);
		st_next = st_reg;

		// mode register; bit 0 is hardware-owned
		if (wr_mode) begin
			st_next.mode[7:1] = mcu_wdata[7:1];
		end
		// a host status read in the clearing cycle still lands
		if (rd_mode) begin
			st_next.mode[fmss_pkg::M_HSR] = 1'b0; // R01
		end
		if (host_status_read) begin
			st_next.mode[fmss_pkg::M_HSR] = 1'b1; // R01
		end

		// branch address; soft reset holds it clear
		if (soft_reset) begin
			st_next.branch = fmss_pkg::BRANCH_RST; // R12
		end else if (wr_br) begin
			st_next.branch = mcu_wdata[4:0]; // R11
		end

		// read data captured at the completed read cycle
		if (mcu_rd) begin
			unique case (mcu_addr)
				fmss_pkg::MODE_OFS: st_next.rdata = st_reg.mode;
				fmss_pkg::NADDR_OFS: st_next.rdata = {3'h0, next_addr}; // R10
				fmss_pkg::STAT_OFS: st_next.rdata = status;
				default: st_next.rdata = 8'h00;
			endcase
		end

		// host register file decode for the current address
		st_next.host_hit = st_reg.mode[fmss_pkg::M_HACC] && // R02
			(st_reg.mode[fmss_pkg::M_HSEL] ? in40 : in60); // R03
		st_next.ext_hit = (in40 | in60) && !st_next.host_hit; // R02 R03

		// ecc error sticks until the next operation or reset
		if (op_start || soft_reset) begin
			st_next.ecc_err = 1'b0;
		end
		if (ecc_last_bit && syndrome_nz && !soft_reset) begin
			st_next.ecc_err = 1'b1; // R15
		end

		// correctable flag only meaningful once shifting is over
		st_next.shift_prev = ecc_shift_ctrl;
		if (ecc_shift_ctrl || soft_reset) begin
			st_next.corr = 1'b0;
		end else if (st_reg.shift_prev) begin
			st_next.corr = corr_found; // R16
		end

		// branch active: read clears, a new branch wins
		if (rd_stat || soft_reset) begin
			st_next.branch_act = 1'b0; // R18
		end
		if (branch_met && !stopped) begin
			st_next.branch_act = 1'b1; // R18
		end

		// mark field active between count mark bit and ECC end
		if (ecc_bytes_done || stopped) begin
			st_next.mark_act = 1'h0; // R20
		end
		if (!ctrl_field[fmss_pkg::C_XFER] &&
			count_field[fmss_pkg::CNT_MARK] && !stopped) begin
			st_next.mark_act = 1'h1; // R20
		end

		// interrupt pin only ever pulls low, so it can be shared
		st_next.int_oe_n = !(st_reg.mode[fmss_pkg::M_INTEN] && int_src); // R04
		st_next.pullup_en = !st_reg.mode[fmss_pkg::M_PUDIS]; // R05

		// general pin becomes an output under sequencer control
		st_next.gpio_oe_n = !st_reg.mode[fmss_pkg::M_SOE]; // R07
		st_next.gpio_o = ctrl_field[fmss_pkg::C_GPIO]; // R07

		// index from pin or from the programmed bit
		st_next.index_act = !soft_reset &&
			(index_in || st_reg.mode[fmss_pkg::M_PIDX]); // R06

		// shared pin: sector edge in hard mode, mark in soft mode
		st_next.pin_prev = mark_or_sector_pin;
		st_next.sector_edge = st_reg.mode[fmss_pkg::M_HARD] && !soft_reset &&
			mark_or_sector_pin && !st_reg.pin_prev; // R08
		st_next.mark_det = !st_reg.mode[fmss_pkg::M_HARD] && !soft_reset &&
			!mark_or_sector_pin; // R08

		// gates dropped whenever the sequencer is stopped
		st_next.rg = read_gate_req && !stopped; // R17 R21
		st_next.wg = write_gate_req && !stopped; // R17 R21
		st_next.hold = soft_reset; // R21
	end

	// hardware reset clears the mode register and flags; pin output enables, pull-up and hold come up set
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '0; // R09 R12 R21
			st_reg.mode <= fmss_pkg::MODE_RST; // R09
			st_reg.branch <= fmss_pkg::BRANCH_RST; // R12
			st_reg.int_oe_n <= 1'b1;
			st_reg.pullup_en <= 1'b1;
			st_reg.gpio_oe_n <= 1'b1;
			st_reg.hold <= 1'b1; // R21
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state flops, int_o tied low
	assign mcu_rdata = st_reg.rdata;
	assign host_file_hit = st_reg.host_hit;
	assign ext_space_hit = st_reg.ext_hit;
	assign fmt_hold = st_reg.hold;
	assign branch_addr = st_reg.branch;
	assign int_o = 1'b0;
	assign int_oe_n = st_reg.int_oe_n;
	assign int_pullup_en = st_reg.pullup_en;
	assign gpio_o = st_reg.gpio_o;
	assign gpio_oe_n = st_reg.gpio_oe_n;
	assign index_active = st_reg.index_act;
	assign hard_sector = st_reg.mode[fmss_pkg::M_HARD];
	assign sector_edge = st_reg.sector_edge;
	assign mark_detect = st_reg.mark_det;
	assign read_gate = st_reg.rg;
	assign write_gate = st_reg.wg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	hsr_set_a: assert property (host_status_read |=> mode_hsr_q) // R01
		else $error("host status read flag not set");
	hsr_clear_a: assert property (mcu_rd && // R01
		mcu_addr == fmss_pkg::MODE_OFS && !host_status_read |=> !mode_hsr_q)
		else $error("host status read flag not cleared by read");
	host_off_a: assert property (!st_reg.mode[1] |=> !host_file_hit) // R02
		else $error("host window decoded while access disabled");
	host_sel_a: assert property (st_reg.mode[1] && st_reg.mode[2] && // R03
		mcu_addr[7:3] == 5'h0C |=> !host_file_hit && ext_space_hit)
		else $error("upper window decoded with lower window selected");
	int_gate_a: assert property (!st_reg.mode[3] |=> int_oe_n) // R04
		else $error("interrupt pin driven while disabled");
	pullup_off_a: assert property (st_reg.mode[4] |=> !int_pullup_en) // R05
		else $error("pull-up left on while disabled");
	prog_index_a: assert property (st_reg.mode[5] && !soft_reset // R06
		|=> index_active)
		else $error("programmed index not active");
	gpio_drive_a: assert property (st_reg.mode[6] |=> !gpio_oe_n && // R07
		gpio_o == $past(ctrl_field[2]))
		else $error("general pin not driven from control bit");
	sector_edge_a: assert property (!st_reg.mode[7] |=> !sector_edge) // R08
		else $error("sector edge in soft sector mode");
	branch_load_a: assert property (mcu_wr && // R11
		mcu_addr == fmss_pkg::NADDR_OFS && !soft_reset
		|=> branch_addr == $past(mcu_wdata[4:0]))
		else $error("branch address not loaded");
	branch_clr_a: assert property (soft_reset |=> branch_addr == 5'h00) // R12
		else $error("branch address not cleared by soft reset");
	next_read_a: assert property (mcu_rd && // R10
		mcu_addr == fmss_pkg::NADDR_OFS
		|=> mcu_rdata == {3'h0, $past(next_addr)})
		else $error("next address read wrong");
	halt_gate_a: assert property (seq_halted ##1 seq_halted // R17
		|=> !read_gate && !write_gate)
		else $error("gates asserted while halted");
	branch_act_a: assert property (mcu_rd && // R18
		mcu_addr == fmss_pkg::STAT_OFS && !branch_met
		|=> !st_reg.branch_act)
		else $error("branch active not cleared by status read");
	am_clear_a: assert property (ecc_bytes_done && (ctrl_field[0] || // R20
		!count_field[7]) |=> !st_reg.mark_act)
		else $error("mark flag not cleared after ECC");
	ecc_err_a: assert property (ecc_last_bit && syndrome_nz && // R15
		!soft_reset |=> st_reg.ecc_err)
		else $error("ECC error flag not set on non-zero syndrome");
	hold_stop_a: assert property (soft_reset |=> fmt_hold && // R21
		!read_gate && !write_gate)
		else $error("formatter not held during soft reset");

	assign mode_hsr_q = st_reg.mode[fmss_pkg::M_HSR];
endmodule : fmss_regs

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic clk, reset_n, mcu_wr, mcu_rd, soft_reset, ecc_shift_ctrl;
	logic [7:0] mcu_addr, mcu_wdata, mcu_rdata, ctrl_field, count_field;
	logic [7:0] read_byte, buf_byte, control_store_byte;
	logic [4:0] next_addr, branch_addr;
	logic host_file_hit, ext_space_hit, fmt_hold, branch_met, seq_halted;
	logic in_ecc_field, op_start, cmp_byte, search_op, ecc_last_bit;
	logic syndrome_nz, corr_found, ecc_bytes_done, host_status_read;
	logic int_src, int_o, int_oe_n, int_pullup_en, gpio_o, gpio_oe_n;
	logic index_in, mark_or_sector_pin, index_active, hard_sector;
	logic sector_edge, mark_detect, read_gate_req, write_gate_req;
	logic read_gate, write_gate;
	int error_cnt = 0;
	int checks = 0;

	fmss_regs i_fmss_regs (.clk, .reset_n, .mcu_addr, .mcu_wdata, .mcu_wr,
		.mcu_rd, .mcu_rdata, .host_file_hit, .ext_space_hit, .soft_reset,
		.ecc_shift_ctrl, .fmt_hold, .next_addr, .ctrl_field, .count_field,
		.branch_met, .seq_halted, .in_ecc_field, .op_start, .branch_addr,
		.cmp_byte, .read_byte, .buf_byte, .control_store_byte, .search_op,
		.ecc_last_bit, .syndrome_nz, .corr_found, .ecc_bytes_done,
		.host_status_read, .int_src, .int_o, .int_oe_n, .int_pullup_en,
		.gpio_o, .gpio_oe_n, .index_in, .mark_or_sector_pin, .index_active,
		.hard_sector, .sector_edge, .mark_detect, .read_gate_req,
		.write_gate_req, .read_gate, .write_gate);
	fmss_mcu_model i_fmss_mcu_model (.clk, .mcu_addr, .mcu_wdata, .mcu_wr,
		.mcu_rd, .mcu_rdata);

	// 100 MHz clock
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [7:0] s, e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		i_fmss_mcu_model.xfer(1, a, 8'h00, 0, q);
	endtask : rd
	// writes come slowly, after one idle cycle
	task automatic wr(input logic [7:0] a, d);
		logic [7:0] q;
		i_fmss_mcu_model.xfer(0, a, d, 1, q);
	endtask : wr
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'h1;
		@(negedge clk);
		s = 1'h0;
	endtask : pulse
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize

	task automatic t_reset;
		logic [7:0] q;
		rd(fmss_pkg::MODE_OFS, q);
		chk(q, fmss_pkg::MODE_RST);
		rd(fmss_pkg::NADDR_OFS, q);
		chk(q, 8'h15);
		chk({3'h0, branch_addr}, 8'h00);
		chk({7'h00, fmt_hold}, 8'h00);
		chk({7'h00, int_pullup_en}, 8'h01);
		$display("reset test done");
	endtask : t_reset

	task automatic t_mode;
		logic [7:0] q, n;
		pulse(host_status_read);
		rd(fmss_pkg::MODE_OFS, q);
		chk(q, 8'h01);
		rd(fmss_pkg::MODE_OFS, q);
		chk(q, 8'h00);
		int_src = 1'h1;
		ctrl_field = 8'h04;
		wr(fmss_pkg::MODE_OFS, 8'hFF);
		rd(fmss_pkg::MODE_OFS, q);
		chk(q, 8'hFE);
		chk({6'h00, int_oe_n, int_pullup_en}, 8'h00);
		chk({7'h00, int_o}, 8'h00);
		chk({6'h00, index_active, hard_sector}, 8'h03);
		chk({6'h00, gpio_oe_n, gpio_o}, 8'h01);
		// count sector pulses over a short span
		n = 8'h00;
		mark_or_sector_pin = 1'h1;
		repeat (4) begin
			@(negedge clk);
			n += sector_edge;
		end
		chk(n, 8'h01);
		wr(fmss_pkg::MODE_OFS, 8'h00);
		mark_or_sector_pin = 1'h0;
		repeat (2) @(negedge clk);
		chk({6'h00, int_oe_n, gpio_oe_n}, 8'h03);
		chk({6'h00, mark_detect, index_active}, 8'h02);
		// a second hardware reset in mid-run
		wr(fmss_pkg::MODE_OFS, 8'h7E);
		reset_n = 1'h0;
		repeat (2) @(negedge clk);
		reset_n = 1'h1;
		rd(fmss_pkg::MODE_OFS, q);
		chk(q, 8'h00);
		$display("mode test done");
	endtask : t_mode

	task automatic t_decode;
		logic [7:0] m [3] = '{8'h00, 8'h02, 8'h06};
		logic [7:0] q, a;
		logic h;
		foreach (m[i]) begin
			wr(fmss_pkg::MODE_OFS, m[i]);
			for (int j = 0; j < 2; j++) begin
				a = j ? fmss_pkg::WIN_HI : fmss_pkg::WIN_LO;
				rd(a + 8'h07, q);
				h = m[i][1] && (m[i][2] == (j == 0));
				chk({6'h00, host_file_hit, ext_space_hit}, {6'h00, h, !h});
			end
		end
		$display("decode test done");
	endtask : t_decode

	task automatic t_branch;
		logic [7:0] q;
		wr(fmss_pkg::NADDR_OFS, 8'h0A);
		chk({3'h0, branch_addr}, 8'h0A);
		read_gate_req = 1'h1;
		write_gate_req = 1'h1;
		repeat (2) @(negedge clk);
		chk({6'h00, read_gate, write_gate}, 8'h03);
		seq_halted = 1'h1;
		repeat (2) @(negedge clk);
		chk({6'h00, read_gate, write_gate}, 8'h00);
		rd(fmss_pkg::STAT_OFS, q);
		chk({7'h00, q[4]}, 8'h01);
		seq_halted = 1'h0;
		soft_reset = 1'h1;
		repeat (2) @(negedge clk);
		chk({3'h0, branch_addr}, 8'h00);
		chk({5'h00, fmt_hold, read_gate, write_gate}, 8'h04);
		wr(fmss_pkg::NADDR_OFS, 8'h1F);
		chk({3'h0, branch_addr}, 8'h00);
		soft_reset = 1'h0;
		read_gate_req = 1'h0;
		write_gate_req = 1'h0;
		$display("branch test done");
	endtask : t_branch

	task automatic t_status;
		logic [7:0] q;
		pulse(branch_met);
		rd(fmss_pkg::STAT_OFS, q);
		chk({7'h00, q[5]}, 8'h01);
		rd(fmss_pkg::STAT_OFS, q);
		chk({7'h00, q[5]}, 8'h00);
		ctrl_field = 8'h03;
		read_byte = 8'h05;
		control_store_byte = 8'h07;
		buf_byte = 8'h05;
		in_ecc_field = 1'h1;
		for (int s = 0; s < 2; s++) begin
			search_op = s[0];
			pulse(op_start);
			pulse(cmp_byte);
			rd(fmss_pkg::STAT_OFS, q);
			chk({6'h00, q[1:0]}, s ? 8'h01 : 8'h02);
		end
		chk({7'h00, q[6]}, 8'h01);
		syndrome_nz = 1'h1;
		pulse(ecc_last_bit);
		corr_found = 1'h1;
		pulse(ecc_shift_ctrl);
		repeat (2) @(negedge clk);
		rd(fmss_pkg::STAT_OFS, q);
		chk({6'h00, q[3:2]}, 8'h03);
		ctrl_field = 8'h00;
		count_field = 8'h80;
		rd(fmss_pkg::STAT_OFS, q);
		chk({7'h00, q[7]}, 8'h01);
		count_field = 8'h00;
		pulse(ecc_bytes_done);
		rd(fmss_pkg::STAT_OFS, q);
		chk({7'h00, q[7]}, 8'h00);
		chk({7'h00, q[6]}, 8'h00);
		in_ecc_field = 1'h0;
		rd(fmss_pkg::STAT_OFS, q);
		chk({6'h00, q[1:0]}, 8'h00);
		$display("status test done");
	endtask : t_status

	// main sequence, every input set at time zero
	initial begin
		{reset_n, soft_reset, ecc_shift_ctrl, branch_met, seq_halted} = 5'h00;
		{in_ecc_field, op_start, cmp_byte, search_op, ecc_last_bit} = 5'h00;
		{syndrome_nz, corr_found, ecc_bytes_done, host_status_read} = 4'h0;
		{int_src, index_in, mark_or_sector_pin} = 3'h0;
		{read_gate_req, write_gate_req} = 2'h0;
		{ctrl_field, count_field, read_byte, buf_byte} = 32'h0;
		control_store_byte = 8'h00;
		next_addr = 5'h15;
		repeat (12) @(negedge clk);
		reset_n = 1'h1;
		t_reset();
		t_mode();
		t_decode();
		t_branch();
		t_status();
		summarize();
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		summarize();
	end
endmodule : tb_top
